// ==== rtl/fpr_top.sv ====
// front panel display, button, ramp and alarm logic of the process controller
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpr_map.svh"
module fpr_top #(
  parameter int unsigned TO_CYC = `FPR_PRM_TO_S * `FPR_CLK_HZ,
  parameter int unsigned BLINK_CYC = `FPR_BLINK_MS * (`FPR_CLK_HZ / 1000),
  parameter int unsigned MIN_CYC = `FPR_SEC_PER_MIN * `FPR_CLK_HZ,
  parameter int unsigned REP_SLOW_CYC = `FPR_REP_SLOW_MS * (`FPR_CLK_HZ / 1000),
  parameter int unsigned REP_FAST_CYC = `FPR_REP_FAST_MS * (`FPR_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // front panel buttons
  input wire logic parameter_step_button_i,
  input wire logic raise_btn_i,
  input wire logic lower_btn_i,
  input wire logic am_btn_i,
  // process and output stage
  input wire logic [15:0] pv_i,
  input wire logic [9:0] ctl_lvl_i,
  input wire logic op1_on_i,
  input wire logic op2_on_i,
  input wire logic sensor_break_i,
  input wire logic comms_active_i,
  // displays
  output logic [2:0] upper_sel_o,
  output logic [15:0] upper_val_o,
  output logic upper_lit_o,
  output logic [15:0] lower_val_o,
  output logic [2:0] lower_alm_o,
  // beacons
  output logic first_output_beacon_o,
  output logic second_output_beacon_o,
  output logic comms_beacon_o,
  output logic ramp_beacon_o,
  output logic manual_beacon_o,
  // alarm outputs and algorithm side
  output logic alarm1_o,
  output logic alarm2_o,
  output logic [15:0] wsp_o,
  output logic [9:0] out_lvl_o,
  output logic manual_o,
  output logic alg_preset_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fpr_clamp(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    fpr_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : fpr_clamp

  // one unit up or down, saturating at the limits, never wrapping
  function automatic logic [15:0] fpr_step(input logic [15:0] v, input logic up,
                                           input logic [15:0] lo, input logic [15:0] hi);
    if (up)
      fpr_step = (v >= hi) ? hi : v + 16'h1;
    else
      fpr_step = (v <= lo) ? lo : v - 16'h1;
  endfunction : fpr_step

  function automatic logic [15:0] fpr_absdiff(input logic [15:0] a, input logic [15:0] b);
    fpr_absdiff = (a > b) ? a - b : b - a;
  endfunction : fpr_absdiff

  fpr_pkg::fpr_top_s st_ff;
  fpr_pkg::fpr_top_s nxt_st;
  fpr_step_if stp ();

  logic setup;
  logic access;
  logic mapped;
  logic lock;
  logic prm_edge;
  logic am_edge;
  logic step;
  logic manual;
  logic ramp_alg;
  logic onoff;
  logic ramping;
  logic hold;
  logic [2:0] cond;
  logic [2:0] cfgd;
  logic [2:0] latch_en;
  logic [2:0] cond_cfg;
  logic [2:0] ann;
  logic [2:0] ann_type;
  logic alarm2;
  logic [17:0] dim_prod;
  logic [9:0] duty;

  // ----------------------------------------------------------------
  // button conditioning
  // ----------------------------------------------------------------
  // a comms lock silences every button, the repeat generator included, except that a held step button still stops the time-out
  fpr_btn #(
    .SLOW_CYC(REP_SLOW_CYC),
    .FAST_CYC(REP_FAST_CYC)
  ) u_btn (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .raise_i(raise_btn_i),
    .lower_i(lower_btn_i),
    .en_i(!lock),
    .stp(stp.gen)
  );

  // press edges and mode decode
  assign lock = st_ff.cfg.panel_lock;
  assign prm_edge = parameter_step_button_i & !st_ff.prm_q & !lock;
  assign am_edge = am_btn_i & !st_ff.am_q & !lock & !st_ff.cfg.am_lock;
  assign step = stp.up | stp.dn;
  assign manual = (st_ff.mode == fpr_pkg::FPR_MAN);
  assign ramp_alg = (st_ff.cfg.alg == `FPR_ALG_RAMP);
  assign onoff = (st_ff.cfg.alg == `FPR_ALG_ONOFF);

  // ----------------------------------------------------------------
  // ramp and alarm conditions
  // ----------------------------------------------------------------
  assign ramping = ramp_alg & (st_ff.wsp != st_ff.tgt);
  // a zero holdback limit means holdback is off
  assign hold = (st_ff.holdback_limit != 16'h0) &
                (fpr_absdiff(pv_i, st_ff.wsp) > st_ff.holdback_limit);
  // bit 0 full_scale_high_alarm, bit 1 full_scale_low_alarm, bit 2 deviation_band_alarm
  assign cond[0] = pv_i > st_ff.alm_hi;
  assign cond[1] = pv_i < st_ff.alm_lo;
  assign cond[2] = fpr_absdiff(pv_i, st_ff.wsp) > st_ff.dev;
  assign cfgd = {st_ff.cfg.dev_mode != `FPR_AM_OFF, st_ff.cfg.lo_mode != `FPR_AM_OFF,
                 st_ff.cfg.hi_mode != `FPR_AM_OFF};
  assign latch_en = {st_ff.cfg.dev_mode == `FPR_AM_LAT, st_ff.cfg.lo_mode == `FPR_AM_LAT,
                     st_ff.cfg.hi_mode == `FPR_AM_LAT};
  assign cond_cfg = cond & cfgd;
  // soft alarms leave the annunciation as soon as they clear
  assign ann = cond_cfg | st_ff.latched;
  assign ann_type = ann[0] ? 3'h1 : (ann[1] ? 3'h2 : (ann[2] ? 3'h4 : 3'h0));
  assign alarm2 = st_ff.cfg.op2_alarm & (st_ff.cfg.op2_sel != 2'h0) &
                  cond[st_ff.cfg.op2_sel - 2'h1];
  // 4-20 duty = 200 + level * 0.8 so the beacon never goes fully dark
  assign dim_prod = st_ff.out_lvl * `FPR_DIM_MUL;
  assign duty = st_ff.cfg.dc_4_20 ? `FPR_DIM_BASE + dim_prod[17:8] : st_ff.out_lvl;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign setup = psel_i & !penable_i;
  assign access = psel_i & penable_i;
  assign mapped = (paddr_i == `FPR_A_CFG) | (paddr_i == `FPR_A_LIM) |
                  (paddr_i == `FPR_A_TGT) | (paddr_i == `FPR_A_RAMP) |
                  (paddr_i == `FPR_A_ALM) | (paddr_i == `FPR_A_DEV) |
                  (paddr_i == `FPR_A_STAT) | (paddr_i == `FPR_A_WSP);
  assign pready_o = access;
  assign pslverr_o = access & !mapped;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic tgt_wr;
    logic [15:0] tgt_new;
    tgt_wr = 1'b0;
    tgt_new = st_ff.tgt;
    nxt_st = st_ff;
    nxt_st.preset = 1'b0;
    nxt_st.prm_q = parameter_step_button_i;
    nxt_st.am_q = am_btn_i;
    nxt_st.init = 1'b0;
    // read data is latched in setup so it is a flop output in the access cycle
    if (setup)
    begin
      case (paddr_i)
        `FPR_A_CFG: nxt_st.rdata = st_ff.cfg;
        `FPR_A_LIM: nxt_st.rdata = {st_ff.sp_hi, st_ff.sp_lo};
        `FPR_A_TGT: nxt_st.rdata = {16'h0, st_ff.tgt};
        `FPR_A_RAMP: nxt_st.rdata = {st_ff.holdback_limit, st_ff.rate};
        `FPR_A_ALM: nxt_st.rdata = {st_ff.alm_lo, st_ff.alm_hi};
        `FPR_A_DEV: nxt_st.rdata = {16'h0, st_ff.dev};
        `FPR_A_STAT: nxt_st.rdata = {17'h0, st_ff.idx, ann, st_ff.latched, cond, hold,
                                     ramping, manual};
        `FPR_A_WSP: nxt_st.rdata = {6'h0, st_ff.out_lvl, st_ff.wsp};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    // writes land on the access edge; status words ignore writes
    if (access & pwrite_i)
    begin
      case (paddr_i)
        `FPR_A_CFG: nxt_st.cfg = fpr_pkg::fpr_cfg_s'(pwdata_i & `FPR_CFG_WMASK);
        `FPR_A_LIM:
        begin
          nxt_st.sp_lo = pwdata_i[15:0];
          nxt_st.sp_hi = pwdata_i[31:16];
        end
        `FPR_A_TGT:
        begin
          tgt_wr = 1'b1;
          tgt_new = fpr_clamp(pwdata_i[15:0], st_ff.sp_lo, st_ff.sp_hi);
        end
        `FPR_A_RAMP:
        begin
          nxt_st.rate = pwdata_i[15:0];
          nxt_st.holdback_limit = pwdata_i[31:16];
        end
        `FPR_A_ALM:
        begin
          nxt_st.alm_hi = pwdata_i[15:0];
          nxt_st.alm_lo = pwdata_i[31:16];
        end
        `FPR_A_DEV: nxt_st.dev = pwdata_i[15:0];
        default: ;
      endcase
    end
    // parameter step: acknowledge first, otherwise scroll
    if (prm_edge)
    begin
      nxt_st.to_cnt = 32'h0;
      if (|st_ff.latched)
        nxt_st.latched = st_ff.latched & cond;
      else
        nxt_st.idx = (st_ff.idx == `FPR_PARAM_N) ? 3'h0 : st_ff.idx + 3'h1;
    end
    else if (st_ff.idx != 3'h0)
    begin
      if (parameter_step_button_i)
        nxt_st.to_cnt = 32'h0;
      else if (st_ff.to_cnt >= TO_CYC - 1)
      begin
        nxt_st.to_cnt = 32'h0;
        nxt_st.idx = 3'h0;
      end
      else
        nxt_st.to_cnt = st_ff.to_cnt + 32'h1;
    end
    // a new latch event wins over an acknowledge in the same cycle
    nxt_st.latched = nxt_st.latched | (cond & latch_en);
    // raise and lower act on the value the lower display shows, except the working setpoint at index 1 and the target shown at index 0 in manual during an alarm
    if (step)
    begin
      case (st_ff.idx)
        3'h0:
        begin
          if (st_ff.cfg.edit_en[0] & manual)
          begin
            if (onoff)
              nxt_st.man_lvl = stp.up ? `FPR_LVL_FULL : 10'h0;
            else
              nxt_st.man_lvl = 10'(fpr_step({6'h0, st_ff.man_lvl}, stp.up, 16'h0,
                                            {6'h0, `FPR_LVL_FULL}));
          end
          else if (st_ff.cfg.edit_en[0])
          begin
            tgt_wr = 1'b1;
            tgt_new = fpr_step(st_ff.tgt, stp.up, st_ff.sp_lo, st_ff.sp_hi);
          end
        end
        3'h2:
          if (st_ff.cfg.edit_en[1])
            nxt_st.rate = fpr_step(st_ff.rate, stp.up, 16'h0, 16'hFFFF);
        3'h3:
          if (st_ff.cfg.edit_en[2])
            nxt_st.holdback_limit = fpr_step(st_ff.holdback_limit, stp.up, 16'h0, 16'hFFFF);
        3'h4:
          if (st_ff.cfg.edit_en[3])
            nxt_st.dev = fpr_step(st_ff.dev, stp.up, 16'h0, 16'hFFFF);
        default: ;
      endcase
    end
    // auto/manual changeover carries the present output level across
    if (am_edge)
    begin
      if (manual)
      begin
        nxt_st.mode = fpr_pkg::FPR_AUTO;
        nxt_st.preset = 1'b1;
      end
      else
      begin
        nxt_st.mode = fpr_pkg::FPR_MAN;
        if (onoff)
          nxt_st.man_lvl = (ctl_lvl_i >= `FPR_LVL_HALF) ? `FPR_LVL_FULL : 10'h0;
        else
          nxt_st.man_lvl = ctl_lvl_i;
      end
    end
    // setpoint engine: immediate follows target, ramp walks one unit per rate tick
    if (tgt_wr)
      nxt_st.tgt = tgt_new;
    if (!ramp_alg)
      nxt_st.wsp = nxt_st.tgt;
    else if (st_ff.init)
    begin
      nxt_st.wsp = pv_i;
      nxt_st.racc = 32'h0;
    end
    else if (tgt_wr & !ramping)
    begin
      nxt_st.wsp = pv_i;
      nxt_st.racc = 32'h0;
    end
    else if (ramping & !hold)
    begin
      if (st_ff.racc + {16'h0, st_ff.rate} >= MIN_CYC)
      begin
        nxt_st.racc = st_ff.racc + {16'h0, st_ff.rate} - MIN_CYC;
        nxt_st.wsp = (st_ff.tgt > st_ff.wsp) ? st_ff.wsp + 16'h1 : st_ff.wsp - 16'h1;
      end
      else
        nxt_st.racc = st_ff.racc + {16'h0, st_ff.rate};
    end
    // flash timebase and beacon pwm
    if (st_ff.blk_cnt >= BLINK_CYC - 1)
    begin
      nxt_st.blk_cnt = 32'h0;
      nxt_st.blink = !st_ff.blink;
    end
    else
      nxt_st.blk_cnt = st_ff.blk_cnt + 32'h1;
    nxt_st.pwm = (st_ff.pwm >= `FPR_LVL_FULL - 10'h1) ? 10'h0 : st_ff.pwm + 10'h1;
    nxt_st.out_lvl = manual ? st_ff.man_lvl : ctl_lvl_i;
    // displays
    nxt_st.up_sel = st_ff.idx;
    nxt_st.up_val = pv_i;
    nxt_st.up_lit = !((|cond_cfg) & st_ff.blink);
    nxt_st.lo_alm = 3'h0;
    case (st_ff.idx)
      3'h0:
      begin
        if (|ann)
        begin
          nxt_st.lo_val = st_ff.tgt;
          nxt_st.lo_alm = st_ff.blink ? ann_type : 3'h0;
        end
        else
          nxt_st.lo_val = manual ? {6'h0, st_ff.man_lvl} : st_ff.tgt;
      end
      3'h1: nxt_st.lo_val = st_ff.wsp;
      3'h2: nxt_st.lo_val = st_ff.rate;
      3'h3: nxt_st.lo_val = st_ff.holdback_limit;
      3'h4: nxt_st.lo_val = st_ff.dev;
      default: nxt_st.lo_val = 16'h0;
    endcase
    // beacons and alarm outputs
    nxt_st.b_op1 = st_ff.cfg.op1_dc ? (st_ff.pwm < duty) : op1_on_i;
    nxt_st.b_op2 = st_ff.cfg.op2_alarm ? alarm2 : op2_on_i;
    nxt_st.b_com = st_ff.cfg.comms_fit & comms_active_i & st_ff.blink;
    nxt_st.b_ramp = ramping &
                    (((st_ff.idx == 3'h1) | hold) ? st_ff.blink : 1'b1);
    nxt_st.b_man = sensor_break_i ? st_ff.blink : manual;
    nxt_st.al1 = |cond_cfg;
    nxt_st.al2 = alarm2;
    // synchronous reset; init is set for the first cycle after it, but the reset algorithm is not the ramp, so no power-up ramp starts
    if (srst_i)
    begin
      nxt_st = '0;
      nxt_st.cfg = fpr_pkg::fpr_cfg_s'(`FPR_CFG_RST);
      nxt_st.sp_hi = `FPR_SP_HI_RST;
      nxt_st.mode = fpr_pkg::FPR_AUTO;
      nxt_st.init = 1'b1;
      nxt_st.up_lit = 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = st_ff.rdata;
  assign upper_sel_o = st_ff.up_sel;
  assign upper_val_o = st_ff.up_val;
  assign upper_lit_o = st_ff.up_lit;
  assign lower_val_o = st_ff.lo_val;
  assign lower_alm_o = st_ff.lo_alm;
  assign first_output_beacon_o = st_ff.b_op1;
  assign second_output_beacon_o = st_ff.b_op2;
  assign comms_beacon_o = st_ff.b_com;
  assign ramp_beacon_o = st_ff.b_ramp;
  assign manual_beacon_o = st_ff.b_man;
  assign alarm1_o = st_ff.al1;
  assign alarm2_o = st_ff.al2;
  assign wsp_o = st_ff.wsp;
  assign out_lvl_o = st_ff.out_lvl;
  assign manual_o = manual;
  assign alg_preset_o = st_ff.preset;
endmodule : fpr_top
`default_nettype wire

// ==== rtl/fpr_map.svh ====
// offsets, encodings, reset values and timing figures of the front panel block
// Functional notes
// - upper shows process value, else parameter abbreviation
// - upper display flashes while configured alarm present
// - lower shows setpoint, manual level, or value
// - lower alternates alarm type and setpoint in alarm
// - output beacons follow outputs; second follows alarm
// - current output beacon dims with level, 4-20 glows
// - comms beacon flashes during host activity
// - ramp beacon lit while setpoint still moving
// - manual beacon steady in manual, flashes sensor break
// - each step press advances to next parameter
// - six second time-out, suppressed while held
// - step press in alarm acknowledges latched alarm
// - raise/lower adjust permitted values, accelerating
// - auto/manual toggles, bumpless output carry-over
// - on/off algorithm limits output to 0/100%
// - auto/manual lockout and panel lock by comms
// - immediate setpoint within limits, passed at once
// - ramp starts at power-up or change, from PV; here only on a target change, the reset algorithm is not the ramp
// - ramp view: target below, step shows instant setpoint
// - holdback exceeded pauses ramp, flashes ramp beacon
// - rate or target change affects active ramp
// - three alarm types energise fitted alarm outputs
// - latched ack only after clear; soft alarm vanishes
// - first alarm output is collective alarm
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH
// timing figures
`define FPR_CLK_HZ 10000000
`define FPR_PRM_TO_S 6
`define FPR_BLINK_MS 500
`define FPR_REP_SLOW_MS 400
`define FPR_REP_FAST_MS 50
`define FPR_SEC_PER_MIN 60
// register byte offsets
`define FPR_A_CFG 8'h00
`define FPR_A_LIM 8'h04
`define FPR_A_TGT 8'h08
`define FPR_A_RAMP 8'h0C
`define FPR_A_ALM 8'h10
`define FPR_A_DEV 8'h14
`define FPR_A_STAT 8'h18
`define FPR_A_WSP 8'h1C
// reset values and masks
`define FPR_CFG_RST 32'hF000_0001
`define FPR_CFG_WMASK 32'hFFF0_00FF
`define FPR_SP_HI_RST 16'h03E8
// encodings
`define FPR_ALG_ONOFF 2'h0
`define FPR_ALG_RAMP 2'h2
`define FPR_AM_OFF 2'h0
`define FPR_AM_LAT 2'h2
`define FPR_LVL_FULL 10'h3E8
`define FPR_LVL_HALF 10'h1F4
`define FPR_DIM_BASE 10'h0C8
`define FPR_DIM_MUL 8'hCD
`define FPR_PARAM_N 3'h4
`endif

// ==== rtl/fpr_pkg.sv ====
// types shared by the front panel block
`default_nettype none
package fpr_pkg;
  typedef enum logic [1:0] {FPR_AUTO = 2'b01, FPR_MAN = 2'b10} fpr_mode_e;
  typedef enum logic [1:0] {FPR_IDLE = 2'b01, FPR_HOLD = 2'b10} fpr_btn_e;

  // configuration word, msb first
  typedef struct packed {
    logic [3:0] edit_en;
    logic [1:0] op2_sel;
    logic [1:0] dev_mode;
    logic [1:0] lo_mode;
    logic [1:0] hi_mode;
    logic [11:0] rsvd;
    logic comms_fit;
    logic op2_alarm;
    logic dc_4_20;
    logic op1_dc;
    logic panel_lock;
    logic am_lock;
    logic [1:0] alg;
  } fpr_cfg_s;

  typedef struct packed {
    fpr_cfg_s cfg;
    logic [15:0] sp_lo;
    logic [15:0] sp_hi;
    logic [15:0] tgt;
    logic [15:0] wsp;
    logic [15:0] rate;
    logic [15:0] holdback_limit;
    logic [15:0] alm_hi;
    logic [15:0] alm_lo;
    logic [15:0] dev;
    logic [31:0] racc;
    logic [31:0] to_cnt;
    logic [31:0] blk_cnt;
    logic [9:0] man_lvl;
    logic [9:0] out_lvl;
    logic [9:0] pwm;
    fpr_mode_e mode;
    logic [2:0] idx;
    logic [2:0] latched;
    logic blink;
    logic prm_q;
    logic am_q;
    logic init;
    logic preset;
    logic [31:0] rdata;
    logic [2:0] up_sel;
    logic [15:0] up_val;
    logic up_lit;
    logic [15:0] lo_val;
    logic [2:0] lo_alm;
    logic b_op1;
    logic b_op2;
    logic b_com;
    logic b_ramp;
    logic b_man;
    logic al1;
    logic al2;
  } fpr_top_s;

  typedef struct packed {
    fpr_btn_e fsm;
    logic [31:0] cnt;
    logic [31:0] ivl;
    logic up;
    logic dn;
  } fpr_btn_s;
endpackage : fpr_pkg
`default_nettype wire

// ==== rtl/fpr_step_if.sv ====
// step pulses from the raise/lower repeat generator
`timescale 1ns/1ps
`default_nettype none
interface fpr_step_if;
  logic up;
  logic dn;
  modport gen (output up, output dn);
  modport take (input up, input dn);
endinterface : fpr_step_if
`default_nettype wire

// ==== rtl/fpr_btn.sv ====
// raise/lower repeat generator with accelerating rate
`timescale 1ns/1ps
`default_nettype none
module fpr_btn #(
  parameter int unsigned SLOW_CYC = 4000000,
  parameter int unsigned FAST_CYC = 500000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // buttons
  input wire logic raise_i,
  input wire logic lower_i,
  input wire logic en_i,
  // step pulses
  fpr_step_if.gen stp
);
  fpr_pkg::fpr_btn_s st_ff;
  fpr_pkg::fpr_btn_s nxt_st;
  logic one;

  // both buttons at once count as no press
  assign one = en_i & (raise_i ^ lower_i);

  // first step on press, then repeats whose interval shrinks by a quarter each time, down to FAST_CYC
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.up = 1'b0;
    nxt_st.dn = 1'b0;
    case (st_ff.fsm)
      fpr_pkg::FPR_IDLE:
      begin
        if (one)
        begin
          nxt_st.up = raise_i;
          nxt_st.dn = lower_i;
          nxt_st.fsm = fpr_pkg::FPR_HOLD;
          nxt_st.cnt = 32'h0;
          nxt_st.ivl = SLOW_CYC;
        end
      end
      fpr_pkg::FPR_HOLD:
      begin
        if (!one)
          nxt_st.fsm = fpr_pkg::FPR_IDLE;
        else if (st_ff.cnt >= st_ff.ivl - 32'h1)
        begin
          nxt_st.up = raise_i;
          nxt_st.dn = lower_i;
          nxt_st.cnt = 32'h0;
          nxt_st.ivl = (st_ff.ivl - (st_ff.ivl >> 2) < FAST_CYC) ? FAST_CYC
                       : st_ff.ivl - (st_ff.ivl >> 2);
        end
        else
          nxt_st.cnt = st_ff.cnt + 32'h1;
      end
      default: nxt_st.fsm = fpr_pkg::FPR_IDLE;
    endcase
    if (srst_i)
    begin
      nxt_st = '0;
      nxt_st.fsm = fpr_pkg::FPR_IDLE;
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    st_ff <= nxt_st;
  end

  assign stp.up = st_ff.up;
  assign stp.dn = st_ff.dn;
endmodule : fpr_btn
`default_nettype wire

// ==== tb/fpr_asserts.sv ====
// port-level assertions of the front panel block
`timescale 1ns/1ps
`default_nettype none
module fpr_asserts (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // watched ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic [15:0] pv_i,
  input wire logic sensor_break_i,
  input wire logic [2:0] upper_sel_o,
  input wire logic [15:0] upper_val_o,
  input wire logic upper_lit_o,
  input wire logic alarm1_o,
  input wire logic manual_beacon_o,
  input wire logic manual_o,
  input wire logic alg_preset_o
);
  // one clock domain; reset silences every check
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_apb_ready: assert property (pready_o == (psel_i && penable_i))
    else $error("pready wrong");
  chk_upper_pv: assert property (!$past(srst_i) |-> upper_val_o == $past(pv_i))
    else $error("upper value stale");
  chk_sel_range: assert property (upper_sel_o <= 3'h4)
    else $error("upper select out of range");
  chk_sel_step: assert property ($changed(upper_sel_o) |->
    upper_sel_o == $past(upper_sel_o) + 3'h1 || upper_sel_o == 3'h0)
    else $error("parameter skipped");
  chk_lit_calm: assert property ((!alarm1_o)[*3] |-> upper_lit_o)
    else $error("upper dark without alarm");
  chk_man_lit: assert property ((manual_o && !sensor_break_i)[*2] |=> manual_beacon_o)
    else $error("manual beacon dark");
  chk_preset_cause: assert property (alg_preset_o == $fell(manual_o))
    else $error("preset not at manual exit");
  chk_preset_pulse: assert property (alg_preset_o |=> !alg_preset_o)
    else $error("preset too long");
endmodule : fpr_asserts
bind fpr_top fpr_asserts u_chk (.*);
`default_nettype wire

// ==== tb/fpr_operator.sv ====
// operator at the panel: presses and holds pushbuttons on request
`timescale 1ns/1ps
`default_nettype none
module fpr_operator (
  // clock
  input wire logic mclk_i,
  // buttons: 0 step, 1 raise, 2 lower, 3 auto/manual
  output logic [3:0] btn_o
);
  initial btn_o = 4'h0;
  // the gap after release makes the next press a fresh edge
  task automatic press(input int b, input int n);
    @(posedge mclk_i);
    btn_o[b] <= 1'b1;
    repeat (n) @(posedge mclk_i);
    btn_o[b] <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : press
endmodule : fpr_operator
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the front panel block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [15:0] pv_i = 16'h64;
  logic [9:0] ctl_lvl_i = 10'h0;
  logic op1_on_i = 1'b0;
  logic op2_on_i = 1'b0;
  logic sensor_break_i = 1'b0;
  logic comms_active_i = 1'b0;
  logic [3:0] btn;
  logic [31:0] prdata_o, rd;
  logic [15:0] upper_val_o, lower_val_o, wsp_o;
  logic [9:0] out_lvl_o, lvl;
  logic [2:0] upper_sel_o, lower_alm_o;
  logic pready_o, pslverr_o, upper_lit_o, first_output_beacon_o, second_output_beacon_o;
  logic comms_beacon_o, ramp_beacon_o, manual_beacon_o, alarm1_o, alarm2_o, manual_o;
  logic alg_preset_o, er;
  int err_count = 0;
  int checks_done = 0;
  int seed = 85;
  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;
  // short counts keep the run brief; every wait below follows them
  fpr_top #(.TO_CYC(50), .BLINK_CYC(4), .MIN_CYC(20), .REP_SLOW_CYC(16), .REP_FAST_CYC(4))
  DUT (.*, .parameter_step_button_i(btn[0]), .raise_btn_i(btn[1]), .lower_btn_i(btn[2]),
    .am_btn_i(btn[3]));
  fpr_operator OPR (.mclk_i, .btn_o(btn));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // outputs are looked at on the falling edge, well clear of updates
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : cyc
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // watchdog sized well above the sequence length
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h03E8_0000, "limit reset");
    apb(1'b1, 8'h40, 32'h1);
    check(32'(er), 32'h1, "unmapped");
    // random process values and output states
    repeat (10)
    begin
      @(posedge mclk_i);
      pv_i <= 16'($random(seed));
      {op1_on_i, op2_on_i, comms_active_i} <= 3'($random(seed));
      cyc(2);
      check(32'(upper_val_o), 32'(pv_i), "upper");
      check(32'(first_output_beacon_o), 32'(op1_on_i), "op1");
      check(32'(second_output_beacon_o), 32'(op2_on_i), "op2");
      check(32'(comms_beacon_o), 32'h0, "no comms board");
    end
    // target above the high limit is clamped
    apb(1'b1, 8'h04, 32'h01F4_0000);
    apb(1'b1, 8'h08, 32'h0000_0258);
    cyc(3);
    check(32'(wsp_o), 32'h1F4, "clamp");
    check(32'(lower_val_o), 32'h1F4, "lower sp");
    // bumpless entry to manual, then raise
    lvl = 10'({$random(seed)} % 500);
    @(posedge mclk_i);
    ctl_lvl_i <= lvl;
    OPR.press(3, 1);
    cyc(0);
    check(32'(manual_o), 32'h1, "manual");
    check(32'(out_lvl_o), 32'(lvl), "bumpless");
    OPR.press(1, 40);
    cyc(0);
    check(32'(out_lvl_o > lvl), 32'h1, "raise");
    OPR.press(3, 1);
    apb(1'b1, 8'h00, 32'hF000_0005);
    OPR.press(3, 1);
    cyc(0);
    check(32'(manual_o), 32'h0, "am lock");
    // on/off algorithm quantises the carried level
    apb(1'b1, 8'h00, 32'hF000_0000);
    @(posedge mclk_i);
    ctl_lvl_i <= 10'h258;
    OPR.press(3, 1);
    cyc(0);
    check(32'(out_lvl_o), 32'h3E8, "on/off");
    OPR.press(3, 1);
    // parameter scroll wraps back to base
    apb(1'b1, 8'h00, 32'hF000_0001);
    for (int i = 1; i < 6; i++)
    begin
      OPR.press(0, 1);
      cyc(0);
      check(32'(upper_sel_o), 32'(i % 5), "scroll");
    end
    OPR.press(0, 1);
    cyc(38);
    check(32'(upper_sel_o), 32'h1, "early");
    cyc(15);
    check(32'(upper_sel_o), 32'h0, "time-out");
    OPR.press(0, 80);
    cyc(0);
    check(32'(upper_sel_o), 32'h1, "held");
    cyc(55);
    // latched high alarm: no ack while present, ack once clear
    apb(1'b1, 8'h10, 32'h0000_00C8);
    apb(1'b1, 8'h00, 32'hF420_0041);
    @(posedge mclk_i);
    pv_i <= 16'h12C;
    cyc(3);
    check(32'(alarm1_o), 32'h1, "alarm");
    check(32'(alarm2_o), 32'h1, "alarm2");
    check(32'(second_output_beacon_o), 32'h1, "op2 alarm");
    OPR.press(0, 1);
    @(posedge mclk_i);
    pv_i <= 16'h32;
    cyc(3);
    check(32'(alarm1_o), 32'h0, "clear");
    check(32'(alarm2_o), 32'h0, "alarm2 clear");
    apb(1'b0, 8'h18, 32'h0);
    check(32'(rd[6]), 32'h1, "latched");
    OPR.press(0, 1);
    apb(1'b0, 8'h18, 32'h0);
    check(32'(rd[6]), 32'h0, "acked");
    // ramp from the process value to the target, one unit a cycle
    apb(1'b1, 8'h0C, 32'h0000_0014);
    apb(1'b1, 8'h00, 32'hF000_0002);
    @(posedge mclk_i);
    pv_i <= 16'h64;
    apb(1'b1, 8'h08, 32'h0000_0096);
    cyc(5);
    check(32'(ramp_beacon_o), 32'h1, "ramping");
    check(32'(lower_val_o), 32'h96, "target");
    cyc(80);
    check(32'(wsp_o), 32'h96, "ramp end");
    check(32'(ramp_beacon_o), 32'h0, "ramp done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
